// file: hw/sar_adc_pkg.sv
// Purpose: Shared constants for the converter sequencer
// Assumes: One 50 MHz clock, 16-bit register port
// Notes:   Offsets are word indexes on the plain register port
package sar_adc_pkg;

  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [3:0] OFF_CTRL1 = 4'h0;
  localparam logic [3:0] OFF_CTRL2 = 4'h1;
  localparam logic [3:0] OFF_RESULT = 4'h2;
  localparam logic [3:0] OFF_CHSEL = 4'h3;
  localparam logic [3:0] OFF_SAMPT = 4'h4;
  localparam logic [3:0] OFF_ISTAT = 4'h5;
  localparam logic [3:0] OFF_IMASK = 4'h6;
  localparam logic [3:0] OFF_DMAADR = 4'h7;

  // ------------------------------------------------------------
  // Control one and control two field positions
  // ------------------------------------------------------------
  localparam int BIT_ON = 15;
  localparam int BIT_IDLE = 13;
  localparam int BIT_BORDER = 12;
  localparam int BIT_RES = 10;
  localparam int BIT_FORM = 8;
  localparam int BIT_SRC = 5;
  localparam int BIT_SAMPLE_CONTROL = 1;
  localparam int BIT_DONE = 0;
  localparam int BIT_SMPI = 2;
  localparam logic [15:0] CTRL1_RST = 16'h0000;
  localparam logic [15:0] CTRL1_WMASK = 16'hb7e0;
  localparam logic [15:0] CTRL2_WMASK = 16'h003c;

  // ------------------------------------------------------------
  // Trigger sources
  // ------------------------------------------------------------
  localparam logic [2:0] SRC_MANUAL = 3'h0;
  localparam logic [2:0] SRC_EXTPIN = 3'h1;
  localparam logic [2:0] SRC_TMR3 = 3'h2;
  localparam logic [2:0] SRC_TMR5 = 3'h4;
  localparam logic [2:0] SRC_AUTO = 3'h7;

  // ------------------------------------------------------------
  // Timing
  // ------------------------------------------------------------
  localparam int CLK_MHZ = 50;
  localparam int RATE10_KSPS = 1100;
  localparam int RATE12_KSPS = 500;
  localparam int CYC10 = (CLK_MHZ * 1000 + RATE10_KSPS - 1) / RATE10_KSPS;
  localparam int CYC12 = (CLK_MHZ * 1000 + RATE12_KSPS - 1) / RATE12_KSPS;
  localparam int NUM_INPUTS = 13;
  localparam logic [7:0] SAMPT_RST = 8'h04;

  typedef enum logic [1:0] {ST_OFF, ST_SAMPLE, ST_CONVERT, ST_WRITE} seq_t;

endpackage : sar_adc_pkg

// file: hw/sar_result_format.sv
// Purpose: Formats a raw result into the 16-bit output word
// Assumes: Raw result is right aligned
// Notes:   Reserved codes give zero
`timescale 1ns/1ps
module sar_result_format (
  input  wire logic [11:0] rawData,  // Raw conversion result
  input  wire logic        res12,    // 12-bit mode
  input  wire logic [1:0]  form,     // Output format code
  output      logic [15:0] dout      // Formatted word
);
  // Zero extend or fill with inverse of top bit
  always_comb begin
    dout = 16'h0000;
    if (res12) begin
      if (form == 2'h0) dout = {4'h0, rawData};                    // RULE13
      else if (form == 2'h1) dout = {{4{~rawData[11]}}, rawData};  // RULE13
    end else begin
      if (form == 2'h0) dout = {6'h00, rawData[9:0]};              // RULE12
      else if (form == 2'h1) dout = {{6{~rawData[9]}}, rawData[9:0]}; // RULE12
    end
  end
endmodule : sar_result_format

// file: hw/sar_adc_sequencer.sv
// Function
// RULE1 - resolution bit picks 10-bit/4ch or 12-bit/1ch
// RULE2 - software turns converter off before resolution change
// RULE3 - 10-bit samples four inputs, 1.1 Msps
// RULE4 - 12-bit samples one channel, 500 ksps
// RULE5 - input select covers inputs zero to twelve
// RULE6 - DMA request whenever done flag sets
// RULE7 - increment-rate field sets pointer advance
// RULE8 - order bit one: conversion-order address
// RULE9 - order bit zero: scatter/gather address
// RULE10 - bit 15 turns converter on
// RULE11 - bit 13 halts converter in idle
// RULE12 - 10-bit output formats
// RULE13 - 12-bit output formats
// RULE14 - auto counter and timer compare triggers
// RULE15 - external pin or sample clear triggers
// RULE16 - software may only clear done flag
// RULE17 - software configures before turning converter on
// RULE18 - done sets after write, clears on sampling
// Purpose: Control of a successive-approximation converter
// Assumes: Analog core converts on convStart, returns anaValid
// Notes:   Register port reads answer one cycle later
`timescale 1ns/1ps
module sar_adc_sequencer
  import sar_adc_pkg::*;
#(
  parameter int DMA_BUF_LOG2 = 2  // Words per input in scatter mode, log2
) (
  input  wire logic        mclk,       // 50 MHz clock
  input  wire logic        srst,       // Sync reset, high
  input  wire logic [3:0]  regAddr,    // Register index
  input  wire logic [15:0] regWdata,   // Write data
  input  wire logic        regWr,      // Write strobe
  input  wire logic        regRd,      // Read strobe
  output      logic [15:0] regRdata_ff, // Read data
  input  wire logic        idleMode,   // Device in idle
  input  wire logic        extIrqPin,  // External pin zero
  input  wire logic        tmr3Match,  // General timer three compare
  input  wire logic        tmr5Match,  // Fifth timer compare
  input  wire logic [11:0] anaData,    // Analog core result
  input  wire logic        anaValid,   // Analog core done pulse
  output      logic        convStart_ff, // Start conversion pulse
  output      logic        sampleEn_ff,  // Sample/hold tracking
  output      logic [3:0]  shMask_ff,    // Sample/hold channels used
  output      logic [3:0]  anaCh_ff,     // Analog input index
  output      logic        dmaReq_ff,    // DMA request pulse
  output      logic [15:0] dmaAddr_ff,   // DMA buffer address
  output      logic [15:0] dmaData_ff,   // Formatted result
  output      logic        irq_ff        // Interrupt level
);

  initial begin
    if (DMA_BUF_LOG2 < 0 || DMA_BUF_LOG2 > 7) $error("DMA_BUF_LOG2 out of range");
  end

  // ------------------------------------------------------------
  // Registers and state
  // ------------------------------------------------------------
  logic [15:0] ctrl1_ff;
  logic [15:0] ctrl2_ff;
  logic [3:0]  chSel_ff;
  logic [7:0]  sampT_ff;
  logic [1:0]  iStat_ff;
  logic [1:0]  iMask_ff;
  logic [15:0] result_ff;
  seq_t        state_ff;
  logic [7:0]  cnt_ff;
  logic [3:0]  smpCnt_ff;
  logic [3:0]  wrPtr_ff;
  logic [1:0]  shIdx_ff;
  logic [2:0]  pinSync_ff;
  logic        pinPrev_ff;
  logic        res12Lat_ff;

  // ------------------------------------------------------------
  // Decoding
  // ------------------------------------------------------------
  wire        convOn   = ctrl1_ff[BIT_ON];                            // RULE10
  wire        halted   = ctrl1_ff[BIT_IDLE] & idleMode;               // RULE11
  wire        running  = convOn & ~halted;
  wire        res12    = ctrl1_ff[BIT_RES];                           // RULE1
  wire [1:0]  form     = ctrl1_ff[BIT_FORM +: 2];
  wire [2:0]  src      = ctrl1_ff[BIT_SRC +: 3];
  wire        order    = ctrl1_ff[BIT_BORDER];
  wire [3:0]  smpi     = ctrl2_ff[BIT_SMPI +: 4];                     // RULE7
  wire        wrCtrl1  = regWr & (regAddr == OFF_CTRL1);
  wire        wrCtrl2  = regWr & (regAddr == OFF_CTRL2);
  wire        wrChSel  = regWr & (regAddr == OFF_CHSEL);
  wire        wrSampT  = regWr & (regAddr == OFF_SAMPT);
  wire        wrIStat  = regWr & (regAddr == OFF_ISTAT);
  wire        wrIMask  = regWr & (regAddr == OFF_IMASK);
  wire        pinStable = (pinSync_ff[2] == pinSync_ff[1]);
  wire        pinRise  = pinStable & pinSync_ff[2] & ~pinPrev_ff;
  wire        sampBit  = ctrl1_ff[BIT_SAMPLE_CONTROL];
  wire        swClrSamp = wrCtrl1 & sampBit & ~regWdata[BIT_SAMPLE_CONTROL];
  wire        swSetSamp = wrCtrl1 & regWdata[BIT_SAMPLE_CONTROL];
  wire [7:0]  convCyc  = res12 ? 8'(CYC12) : 8'(CYC10);               // RULE3 RULE4
  wire [3:0]  chLimit  = (chSel_ff > 4'(NUM_INPUTS - 1)) ? 4'(NUM_INPUTS - 1) : chSel_ff;
  wire [15:0] fmtData;

  // Trigger that ends sampling
  logic trig;
  always_comb begin
    unique case (src)
      SRC_AUTO:   trig = (cnt_ff == 8'h00);                           // RULE14
      SRC_TMR5:   trig = tmr5Match;                                   // RULE14
      SRC_TMR3:   trig = tmr3Match;                                   // RULE14
      SRC_EXTPIN: trig = pinRise;                                     // RULE15
      SRC_MANUAL: trig = swClrSamp;                                   // RULE15
      default:    trig = 1'b0;
    endcase
  end

  // Scatter/gather or conversion-order address
  function automatic logic [15:0] bufAddr(input logic ord, input logic [3:0] ch,
                                          input logic [3:0] ptr);
    logic [15:0] a;
    a = 16'h0000;
    if (ord) a = {12'h000, ptr};                                      // RULE8
    else a = 16'((32'(ch) << DMA_BUF_LOG2) + 32'(ptr) % (1 << DMA_BUF_LOG2)); // RULE9
    return a;
  endfunction : bufAddr

  wire [3:0]  curCh    = res12 ? chLimit : 4'(chLimit + {2'h0, shIdx_ff}); // RULE5
  wire [3:0]  curChLim = (curCh > 4'(NUM_INPUTS - 1)) ? 4'(NUM_INPUTS - 1) : curCh;
  wire [15:0] nxtAddr  = bufAddr(order, curChLim, wrPtr_ff);
  wire        lastSh   = res12 | (shIdx_ff == 2'h3);

  sar_result_format u_fmt (
    .rawData (anaData),
    .res12   (res12Lat_ff),
    .form    (form),
    .dout    (fmtData)
  );

  // ------------------------------------------------------------
  // Pin synchroniser
  // ------------------------------------------------------------
  always_ff @(posedge mclk) begin
    if (srst) begin
      pinSync_ff <= 3'h0;
      pinPrev_ff <= 1'b0;
    end else begin
      pinSync_ff <= {pinSync_ff[1:0], extIrqPin};
      if (pinStable) pinPrev_ff <= pinSync_ff[2];
    end
  end

  // ------------------------------------------------------------
  // Sequencer
  // ------------------------------------------------------------
  seq_t       nxt_state;
  logic       doneSet;
  always_comb begin
    nxt_state = state_ff;
    doneSet = 1'b0;
    unique case (state_ff)
      ST_OFF:     if (running && (swSetSamp || sampBit)) nxt_state = ST_SAMPLE;
      ST_SAMPLE:  if (!running) nxt_state = ST_OFF;
                  else if (trig) nxt_state = ST_CONVERT;
      ST_CONVERT: if (!running) nxt_state = ST_OFF;
                  else if (anaValid || cnt_ff == 8'h00) nxt_state = ST_WRITE;
      ST_WRITE: begin
        nxt_state = lastSh ? ST_OFF : ST_CONVERT;
        doneSet = lastSh;
      end
    endcase
  end

  // State, counters and analog handshake
  always_ff @(posedge mclk) begin
    if (srst) begin
      state_ff     <= ST_OFF;
      cnt_ff       <= 8'h00;
      shIdx_ff     <= 2'h0;
      convStart_ff <= 1'b0;
      sampleEn_ff  <= 1'b0;
      shMask_ff    <= 4'h0;
      anaCh_ff     <= 4'h0;
      res12Lat_ff  <= 1'b0;
    end else begin
      state_ff     <= nxt_state;
      convStart_ff <= (nxt_state == ST_CONVERT) && (state_ff != ST_CONVERT);
      sampleEn_ff  <= (nxt_state == ST_SAMPLE);
      shMask_ff    <= !convOn ? 4'h0 : (res12 ? 4'h1 : 4'hf);         // RULE1 RULE3 RULE4
      anaCh_ff     <= curChLim;
      res12Lat_ff  <= res12;
      if (nxt_state == ST_SAMPLE && state_ff != ST_SAMPLE) cnt_ff <= sampT_ff;
      else if (nxt_state == ST_CONVERT && state_ff != ST_CONVERT) cnt_ff <= convCyc;
      else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
      if (state_ff == ST_WRITE) shIdx_ff <= lastSh ? 2'h0 : 2'(shIdx_ff + 2'h1);
      else if (state_ff == ST_OFF) shIdx_ff <= 2'h0;
    end
  end

  // Result capture and DMA output
  always_ff @(posedge mclk) begin
    if (srst) begin
      result_ff  <= 16'h0000;
      dmaData_ff <= 16'h0000;
      dmaAddr_ff <= 16'h0000;
      dmaReq_ff  <= 1'b0;
      wrPtr_ff   <= 4'h0;
      smpCnt_ff  <= 4'h0;
    end else begin
      dmaReq_ff <= doneSet;                                           // RULE6
      if (state_ff == ST_CONVERT && nxt_state == ST_WRITE) begin
        result_ff  <= fmtData;
        dmaData_ff <= fmtData;
        dmaAddr_ff <= nxtAddr;                                        // RULE8 RULE9
      end
      if (!convOn) begin
        wrPtr_ff  <= 4'h0;
        smpCnt_ff <= 4'h0;
      end else if (doneSet) begin
        if (smpCnt_ff == smpi) begin                                  // RULE7
          smpCnt_ff <= 4'h0;
          wrPtr_ff  <= 4'(wrPtr_ff + 4'h1);
        end else begin
          smpCnt_ff <= 4'(smpCnt_ff + 4'h1);
        end
      end
    end
  end

  // ------------------------------------------------------------
  // Control registers; hardware owns sample and done bits
  // ------------------------------------------------------------
  logic [15:0] nxt_ctrl1;
  always_comb begin
    nxt_ctrl1 = ctrl1_ff;
    if (wrCtrl1) nxt_ctrl1 = (ctrl1_ff & ~CTRL1_WMASK) | (regWdata & CTRL1_WMASK); // RULE10
    if (wrCtrl1 && !regWdata[BIT_DONE]) nxt_ctrl1[BIT_DONE] = 1'b0;                // RULE16
    if (wrCtrl1) nxt_ctrl1[BIT_SAMPLE_CONTROL] = regWdata[BIT_SAMPLE_CONTROL];
    if (nxt_state == ST_SAMPLE && state_ff != ST_SAMPLE) begin
      nxt_ctrl1[BIT_SAMPLE_CONTROL] = 1'b1;
      nxt_ctrl1[BIT_DONE] = 1'b0;                                     // RULE18
    end
    if (state_ff == ST_SAMPLE && nxt_state != ST_SAMPLE) nxt_ctrl1[BIT_SAMPLE_CONTROL] = 1'b0;
    if (doneSet) nxt_ctrl1[BIT_DONE] = 1'b1;                          // RULE16 RULE18
    // Sample request may arrive in the same write that turns the converter on
    if (!nxt_ctrl1[BIT_ON]) nxt_ctrl1[BIT_SAMPLE_CONTROL] = 1'b0;
  end

  // Register writes
  always_ff @(posedge mclk) begin
    if (srst) begin
      ctrl1_ff <= CTRL1_RST;
      ctrl2_ff <= 16'h0000;
      chSel_ff <= 4'h0;
      sampT_ff <= SAMPT_RST;
      iMask_ff <= 2'h0;
    end else begin
      ctrl1_ff <= nxt_ctrl1;
      if (wrCtrl2) ctrl2_ff <= regWdata & CTRL2_WMASK;
      if (wrChSel) chSel_ff <= regWdata[3:0];
      if (wrSampT) sampT_ff <= regWdata[7:0];
      if (wrIMask) iMask_ff <= regWdata[1:0];
    end
  end

  // ------------------------------------------------------------
  // Interrupt status: set wins over write-one-to-clear
  // ------------------------------------------------------------
  wire [1:0] evt = {state_ff == ST_CONVERT && nxt_state == ST_WRITE, doneSet};
  always_ff @(posedge mclk) begin
    if (srst) begin
      iStat_ff <= 2'h0;
      irq_ff   <= 1'b0;
    end else begin
      iStat_ff <= (iStat_ff & ~(wrIStat ? regWdata[1:0] : 2'h0)) | evt;
      irq_ff   <= |(((iStat_ff & ~(wrIStat ? regWdata[1:0] : 2'h0)) | evt) & iMask_ff);
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  logic [15:0] rdMux;
  always_comb begin
    unique case (regAddr)
      OFF_CTRL1:  rdMux = ctrl1_ff;
      OFF_CTRL2:  rdMux = ctrl2_ff;
      OFF_RESULT: rdMux = result_ff;
      OFF_CHSEL:  rdMux = {12'h000, chSel_ff};
      OFF_SAMPT:  rdMux = {8'h00, sampT_ff};
      OFF_ISTAT:  rdMux = {14'h0000, iStat_ff};
      OFF_IMASK:  rdMux = {14'h0000, iMask_ff};
      OFF_DMAADR: rdMux = dmaAddr_ff;
      default:    rdMux = 16'h0000;
    endcase
  end

  always_ff @(posedge mclk) begin
    if (srst) regRdata_ff <= 16'h0000;
    else regRdata_ff <= regRd ? rdMux : 16'h0000;
  end

endmodule : sar_adc_sequencer

// file: bench/sar_analog_model.sv
// Purpose: Analog core model answering conversion starts
// Assumes: Result is offered on the done pulse only
// Notes:   Data line toggles every cycle outside the done pulse
`timescale 1ns/1ps
module sar_analog_model #(
  parameter int DLY = 5  // Cycles from start to done
) (
  input  wire logic        mclk,        // Clock
  input  wire logic        srst,        // Sync reset
  input  wire logic        convStart,   // Start pulse
  input  wire logic [11:0] level,       // Value to return
  output      logic [11:0] anaData_ff,  // Result line
  output      logic        anaValid_ff  // Done pulse
);
  logic [7:0] cnt_ff;

  // Count down from start, pulse done, then scramble the line
  always_ff @(posedge mclk) begin
    if (srst) begin
      cnt_ff <= 8'h00;
      anaValid_ff <= 1'b0;
      anaData_ff <= 12'h000;
    end else begin
      anaValid_ff <= (cnt_ff == 8'h01);
      anaData_ff <= (cnt_ff == 8'h01) ? level : ~anaData_ff;
      if (convStart) cnt_ff <= 8'(DLY);
      else if (cnt_ff != 8'h00) cnt_ff <= cnt_ff - 8'h01;
    end
  end
endmodule : sar_analog_model

// file: bench/sar_adc_sequencer_assertions.sv
// Purpose: Port checks for the sequencer
// Assumes: Shadows follow control and mask writes
// Notes:   Bound to every sequencer instance
`timescale 1ns/1ps
module sar_adc_checker
  import sar_adc_pkg::*;
#(parameter int DMA_BUF_LOG2 = 2) (
  input wire logic mclk, srst, regWr, regRd, idleMode, extIrqPin, tmr3Match, tmr5Match,
  input wire logic anaValid, convStart_ff, sampleEn_ff, dmaReq_ff, irq_ff,
  input wire logic [3:0] regAddr, shMask_ff, anaCh_ff,
  input wire logic [15:0] regWdata, regRdata_ff, dmaAddr_ff, dmaData_ff,
  input wire logic [11:0] anaData
);
  logic [15:0] ctrlSh_ff;
  logic [15:0] maskSh_ff;
  logic [1:0]  quietCnt_ff;
  wire         quiet = (quietCnt_ff == 2'h3);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (srst);

  // Shadows of register writes and cycles since a control write
  always_ff @(posedge mclk) begin
    if (srst) ctrlSh_ff <= 16'h0000;
    else if (regWr && regAddr == OFF_CTRL1) ctrlSh_ff <= regWdata;
    if (srst) maskSh_ff <= 16'h0000;
    else if (regWr && regAddr == OFF_IMASK) maskSh_ff <= regWdata;
    if (srst || (regWr && regAddr == OFF_CTRL1)) quietCnt_ff <= 2'h0;
    else if (!quiet) quietCnt_ff <= quietCnt_ff + 2'h1;
  end

  a_sh_mask: assert property (quiet && !idleMode |-> shMask_ff ==
    (!ctrlSh_ff[BIT_ON] ? 4'h0 : ctrlSh_ff[BIT_RES] ? 4'h1 : 4'hf))
    else $error("sample/hold mask wrong for mode");
  a_dma_single: assert property (dmaReq_ff |=> !dmaReq_ff)
    else $error("dma request longer than one cycle");
  a_irq_masked: assert property (maskSh_ff == 16'h0000 && $past(maskSh_ff) == 16'h0000
    |-> !irq_ff) else $error("interrupt with all sources masked");
  a_chan_range: assert property (anaCh_ff <= 4'hc)
    else $error("input index above twelve");
  a_off_quiet: assert property (quiet && !ctrlSh_ff[BIT_ON]
    |-> !convStart_ff && !sampleEn_ff) else $error("activity while converter off");
  a_idle_halt: assert property (quiet && ctrlSh_ff[BIT_IDLE] && idleMode
    && $past(idleMode, 3) |-> !convStart_ff) else $error("conversion during idle halt");
  a_fmt_ten: assert property (dmaReq_ff && !ctrlSh_ff[BIT_RES] && !ctrlSh_ff[9]
    |-> dmaData_ff[15:10] == (ctrlSh_ff[8] ? {6{~dmaData_ff[9]}} : 6'h00))
    else $error("ten bit format upper bits wrong");
  a_fmt_twelve: assert property (dmaReq_ff && ctrlSh_ff[BIT_RES] && !ctrlSh_ff[9]
    |-> dmaData_ff[15:12] == (ctrlSh_ff[8] ? {4{~dmaData_ff[11]}} : 4'h0))
    else $error("twelve bit format upper bits wrong");

  c_ten: cover property (dmaReq_ff && !ctrlSh_ff[BIT_RES]);
  c_twelve: cover property (dmaReq_ff && ctrlSh_ff[BIT_RES]);
  c_irq: cover property (irq_ff);
endmodule : sar_adc_checker

bind sar_adc_sequencer sar_adc_checker #(.DMA_BUF_LOG2(DMA_BUF_LOG2)) chk (
  .mclk(mclk), .srst(srst), .regWr(regWr), .regRd(regRd), .idleMode(idleMode),
  .extIrqPin(extIrqPin), .tmr3Match(tmr3Match), .tmr5Match(tmr5Match),
  .anaValid(anaValid), .convStart_ff(convStart_ff), .sampleEn_ff(sampleEn_ff),
  .dmaReq_ff(dmaReq_ff), .irq_ff(irq_ff), .regAddr(regAddr), .shMask_ff(shMask_ff),
  .anaCh_ff(anaCh_ff), .regWdata(regWdata), .regRdata_ff(regRdata_ff),
  .dmaAddr_ff(dmaAddr_ff), .dmaData_ff(dmaData_ff), .anaData(anaData));

// file: bench/sar_adc_sequencer_tb.sv
// Purpose: Random and corner tests of the sequencer
// Assumes: Register port master, analog model on the far side
// Notes:   One 50 MHz clock, reset held 10 cycles
`timescale 1ns/1ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin n_errors++; \
  $display("ERROR %0t got %h want %h", $time, g, e); end end
module sar_adc_sequencer_tb;
  import sar_adc_pkg::*;
  logic mclk = 1'b0, srst = 1'b1, regWr = 1'b0, regRd = 1'b0, idleMode = 1'b0;
  logic extIrqPin = 1'b0, tmr3Match = 1'b0, tmr5Match = 1'b0;
  logic [3:0] regAddr = 4'h0, shMask, anaCh;
  logic [15:0] regWdata = 16'h0000, rdVal, rdata, dmaAddr, dmaData;
  logic [11:0] level = 12'h000, anaData;
  logic anaValid, convStart, sampleEn, dmaReq, irq;
  int n_errors = 0, checks_done = 0, nConv = 0, base;

  always #10 mclk = ~mclk;
  always @(posedge mclk) if (convStart === 1'b1) nConv++;

  sar_adc_sequencer #(.DMA_BUF_LOG2(2)) dut (
    .mclk(mclk), .srst(srst), .regAddr(regAddr), .regWdata(regWdata), .regWr(regWr),
    .regRd(regRd), .regRdata_ff(rdata), .idleMode(idleMode), .extIrqPin(extIrqPin),
    .tmr3Match(tmr3Match), .tmr5Match(tmr5Match), .anaData(anaData),
    .anaValid(anaValid), .convStart_ff(convStart), .sampleEn_ff(sampleEn),
    .shMask_ff(shMask), .anaCh_ff(anaCh), .dmaReq_ff(dmaReq), .dmaAddr_ff(dmaAddr),
    .dmaData_ff(dmaData), .irq_ff(irq));
  sar_analog_model #(.DLY(5)) ana (.mclk(mclk), .srst(srst), .convStart(convStart),
    .level(level), .anaData_ff(anaData), .anaValid_ff(anaValid));

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    @(posedge mclk);
    regAddr <= a;
    regWdata <= d;
    regWr <= 1'b1;
    @(posedge mclk);
    regWr <= 1'b0;
  endtask : wr
  task automatic rd(input logic [3:0] a);
    @(posedge mclk);
    regAddr <= a;
    regRd <= 1'b1;
    @(posedge mclk);
    regRd <= 1'b0;
    @(negedge mclk);
    rdVal = rdata;
  endtask : rd
  task automatic waitDma();
    int i;
    i = 0;
    do @(negedge mclk); while (dmaReq !== 1'b1 && ++i < 3000);
    `CHK(dmaReq, 1'b1)
  endtask : waitDma
  function automatic logic [15:0] fmtExp(logic [11:0] d, logic r12, logic [1:0] f);
    if (f == 2'h0) return r12 ? {4'h0, d} : {6'h00, d[9:0]};
    if (f == 2'h1) return r12 ? {{4{~d[11]}}, d} : {{6{~d[9]}}, d[9:0]};
    return 16'h0000;
  endfunction : fmtExp
  task automatic end_sim();
    $display("checks %0d mismatches %0d", checks_done, n_errors);
    if (n_errors == 0 && checks_done > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim

  // Watchdog
  initial begin
    #1000000;
    n_errors++;
    $display("ERROR %0t watchdog expired", $time);
    end_sim();
  end

  // Main sequence
  initial begin
    logic [15:0] cfg;
    logic [3:0]  ch;
    logic [2:0]  src;
    logic [1:0]  fc;
    void'($urandom(32'h94791cef));
    repeat (10) @(posedge mclk);
    srst <= 1'b0;
    rd(OFF_CTRL1);
    `CHK(rdVal, CTRL1_RST)
    rd(OFF_SAMPT);
    `CHK(rdVal, 16'h0004)
    rd(4'hf);
    `CHK(rdVal, 16'h0000)
    wr(OFF_CTRL1, 16'h4810);
    rd(OFF_CTRL1);
    `CHK(rdVal, 16'h0000)
    wr(OFF_CTRL2, 16'hffff);
    rd(OFF_CTRL2);
    `CHK(rdVal, 16'h003c)
    $display("test registers done");
    // Every mode and format, manual trigger, random data and channel
    for (int r = 0; r < 2; r++) begin
      for (int f = 0; f < 3; f++) begin
        ch = 4'($urandom_range(12));
        level <= 12'($urandom);
        fc = (r == 1 && f == 2) ? 2'h3 : 2'(f);
        cfg = 16'h8000 | 16'(r << BIT_RES) | 16'(fc) << BIT_FORM;
        wr(OFF_CHSEL, {12'h000, ch});
        wr(OFF_CTRL1, 16'h0000);
        wr(OFF_CTRL1, cfg | 16'h0002);
        repeat (3) @(negedge mclk);
        `CHK(shMask, (r == 1) ? 4'h1 : 4'hf)
        if (r == 1) `CHK(anaCh, ch)
        base = nConv;
        wr(OFF_CTRL1, cfg);
        waitDma();
        `CHK(nConv - base, (r == 1) ? 1 : 4)
        `CHK(dmaData, fmtExp(level, 1'(r), fc))
        if (r == 1) `CHK(dmaAddr[15:2], {10'h000, ch})
      end
    end
    $display("test formats done");
    // Done flag, status, mask and clear
    rd(OFF_CTRL1);
    `CHK(rdVal[BIT_DONE], 1'b1)
    rd(OFF_ISTAT);
    `CHK(rdVal[0], 1'b1)
    `CHK(irq, 1'b0)
    wr(OFF_IMASK, 16'h0001);
    repeat (2) @(negedge mclk);
    `CHK(irq, 1'b1)
    wr(OFF_ISTAT, 16'h0003);
    repeat (2) @(negedge mclk);
    `CHK(irq, 1'b0)
    wr(OFF_CTRL1, 16'h0000);
    wr(OFF_CTRL1, 16'h0001);
    rd(OFF_CTRL1);
    `CHK(rdVal[BIT_DONE], 1'b0)
    $display("test interrupt done");
    // Hardware trigger sources
    for (int s = 0; s < 4; s++) begin
      src = (s == 0) ? SRC_EXTPIN : (s == 1) ? SRC_TMR3 : (s == 2) ? SRC_TMR5 : SRC_AUTO;
      wr(OFF_CTRL1, 16'h0000);
      wr(OFF_CTRL1, 16'h8002 | 16'(src) << BIT_SRC);
      @(posedge mclk);
      extIrqPin <= (s == 0);
      tmr3Match <= (s == 1);
      tmr5Match <= (s == 2);
      @(posedge mclk);
      tmr3Match <= 1'b0;
      tmr5Match <= 1'b0;
      waitDma();
      @(posedge mclk);
      extIrqPin <= 1'b0;
    end
    $display("test triggers done");
    // Idle halt blocks auto conversion, idle continue lets it run
    wr(OFF_CTRL1, 16'h0000);
    idleMode <= 1'b1;
    wr(OFF_CTRL1, 16'ha0e2);
    base = nConv;
    repeat (200) @(posedge mclk);
    `CHK(nConv - base, 0)
    wr(OFF_CTRL1, 16'h0000);
    wr(OFF_CTRL1, 16'h80e2);
    waitDma();
    @(posedge mclk);
    idleMode <= 1'b0;
    $display("test idle done");
    end_sim();
  end
endmodule : sar_adc_sequencer_tb
